// [dpio_pkg.sv]
// Package: register map, field layout, reset values and carriers for the dual port block
package dpio_pkg;
  localparam int          DPIO_AW            = 8;
  // Register offsets
  localparam logic [7:0]  DPIO_P2_LATCH_OFF  = 8'h02;
  localparam logic [7:0]  DPIO_P2_PIN_OFF    = 8'h0e;
  localparam logic [7:0]  DPIO_P3_LATCH_OFF  = 8'h03;
  localparam logic [7:0]  DPIO_P3_DIR_OFF    = 8'h0a;
  localparam logic [7:0]  DPIO_P3_PIN_OFF    = 8'h0f;
  localparam logic [7:0]  DPIO_ADC_CTRL_OFF  = 8'h21;
  localparam logic [7:0]  DPIO_MODE_OFF      = 8'h39;
  // Field positions
  localparam int          DPIO_ANA_DIS_BIT   = 4;
  localparam int          DPIO_CHAN_SEL_LSB  = 0;
  localparam int          DPIO_CHAN_SEL_W    = 3;
  localparam int          DPIO_DUAL_BIT      = 0;
  localparam int          DPIO_STOP_BIT      = 1;
  localparam int          DPIO_STOP_PIN      = 0;
  localparam int          DPIO_INT_PIN       = 0;
  localparam int          DPIO_OSC_IN_PIN    = 1;
  localparam int          DPIO_OSC_OUT_PIN   = 2;
  localparam int          DPIO_AIN_FIRST     = 2;
  localparam int          DPIO_AIN_COUNT     = 6;
  // Reset values
  localparam logic [2:0]  DPIO_P2_LATCH_RST  = 3'h7;
  localparam logic [7:0]  DPIO_P3_LATCH_RST  = 8'h00;
  localparam logic [7:0]  DPIO_P3_DIR_RST    = 8'h00;
  localparam logic [7:0]  DPIO_ADC_CTRL_RST  = 8'h10;
  localparam logic [7:0]  DPIO_MODE_RST      = 8'h00;
  // Unimplemented upper bits of port-2 reads
  localparam logic [4:0]  DPIO_P2_UPPER_RD   = 5'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bitop;
  } dpio_req_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dpio_drive_s;
endpackage

// [dpio_sync.sv]
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module dpio_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // Refuse an empty bank at elaboration
  if (W < 1)
  begin : g_bad_width
    $error("dpio_sync: width must be at least one");
  end

  // First stage feeds only the second
  always_comb
  begin
    nxt_meta = d;
    nxt_q    = meta_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_ff <= '0;
      q_ff    <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule

// [dpio_top.sv]
// Three-bit and eight-bit parallel ports with analog and resonator sharing
`timescale 1ns/10ps
// Function
// - Three-bit port output latch resets to all ones.
// - Dual-clock mode gives pins one and two to the resonator.
// - Interrupt pin falling edge sets its latch even when driven as output.
// - Three-bit latch register reads latches; eight-bit one reads pin levels except on analog pins; pin-state registers read pin levels.
// - Bits seven to three of three-bit port reads carry no meaning.
// - Stop-shared pin floats in stop mode regardless of output enable.
// - Reset clears direction and latch, sets analog-disable, all pins inputs.
// - Direction bit one drives the matching latch bit onto the pin.
// - Analog-disable zero turns selected pins analog, ignoring latch and direction.
// - Read returns latch for analog pins, pin level for others.
// - Writes never drive latch data onto analog pins.
// - Bit operations write pin levels back into input-mode latches.
// - Pin outputs change in the write cycle's second state.
// - Pin levels are sampled in the read cycle's first state.
module dpio_top
  import dpio_pkg::*;
#(
  parameter int P3_W = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic [DPIO_AW-1:0]   reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic                 reg_bitop,
  output logic      [7:0]           reg_rdata,
  input  wire logic [2:0]           port2_pin_in,
  output logic      [2:0]           port2_pin_out,
  output logic      [2:0]           port2_pin_oe,
  input  wire logic [P3_W-1:0]      port3_pin_in,
  output logic      [P3_W-1:0]      port3_pin_out,
  output logic      [P3_W-1:0]      port3_pin_oe,
  output logic      [P3_W-1:0]      analog_channel_input,
  output logic                      low_freq_osc_en,
  output logic                      port2_int_latch_set,
  output logic      [3:0]           key_wakeup_input
);
  // The channel map and bit-op merge are fixed at eight pins, so refuse any other width
  if (P3_W != 8)
  begin : g_bad_width
    $error("dpio_top: eight-bit port width must be 8");
  end

  dpio_req_s    req;
  dpio_drive_s  p3_drv;
  logic [2:0]   p2_sync;
  logic [7:0]   p3_sync;

  // Committed register state and next values
  logic [2:0]   port2_output_latch_ff, nxt_port2_output_latch;
  logic [7:0]   port3_output_latch_ff, nxt_port3_output_latch;
  logic [7:0]   port3_direction_ff,    nxt_port3_direction;
  logic [7:0]   converter_control_one_ff, nxt_converter_control_one;
  logic [7:0]   mode_ff,               nxt_mode;
  logic [7:0]   rdata_ff,              nxt_rdata;
  logic [2:0]   p2_out_ff,             nxt_p2_out;
  logic [2:0]   p2_oe_ff,              nxt_p2_oe;
  logic [7:0]   p3_out_ff,             nxt_p3_out;
  logic [7:0]   p3_oe_ff,              nxt_p3_oe;
  logic [7:0]   ain_ff,                nxt_ain;
  logic         osc_ff,                nxt_osc;
  logic         int_prev_ff,           nxt_int_prev;
  logic         int_set_ff,            nxt_int_set;
  logic [3:0]   wake_ff,               nxt_wake;

  // Decoded control fields and per-pin views
  logic         analog_input_disable;
  logic [2:0]   analog_channel_select;
  logic         dual_clock;
  logic         stop_mode;
  logic [7:0]   analog_mask;
  logic [2:0]   p2_level;
  wire  [7:0]   p3_read;

  // Pin inputs cross into mclk through two flops before any use
  dpio_sync #(.W(3)) u_sync2 (
    .mclk (mclk),
    .srst (srst),
    .d    (port2_pin_in),
    .q    (p2_sync)
  );

  dpio_sync #(.W(8)) u_sync3 (
    .mclk (mclk),
    .srst (srst),
    .d    (port3_pin_in),
    .q    (p3_sync)
  );

  // Decode one channel number to a one-hot analog pin mask
  function automatic logic [7:0] ain_decode(input logic en, input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h00;
    // Channels past the last pin select nothing rather than wrap
    if (en && (sel < 3'(DPIO_AIN_COUNT)))
      m[3'(sel + 3'(DPIO_AIN_FIRST))] = 1'b1;
    return m;
  endfunction

  // Bus request bundle
  always_comb
  begin
    req.addr  = reg_addr;
    req.wdata = reg_wdata;
    req.wr    = reg_wr;
    req.rd    = reg_rd;
    req.bitop = reg_bitop;
  end

  // Control field decode
  // The mask is combinational so a bit-op write sees the new selection at once
  always_comb
  begin
    analog_input_disable  = converter_control_one_ff[DPIO_ANA_DIS_BIT];
    analog_channel_select = converter_control_one_ff[DPIO_CHAN_SEL_LSB +: DPIO_CHAN_SEL_W];
    dual_clock            = mode_ff[DPIO_DUAL_BIT];
    stop_mode             = mode_ff[DPIO_STOP_BIT];
    analog_mask           = ain_decode(!analog_input_disable, analog_channel_select);
  end

  // Three-bit port reads its synchronised pins directly
  always_comb
  begin
    p2_level = p2_sync;
  end

  // Port-three read view: analog pins show their latch, the rest the sampled level;
  // the latch stands in so a read never depends on a pin under conversion
  for (genvar b = 0; b < P3_W; b++)
  begin : g_p3_read
    assign p3_read[b] = analog_mask[b] ? port3_output_latch_ff[b] : p3_sync[b];
  end

  // Register writes, with bit operations merging pin levels for inputs
  // The slave never stalls, so every write strobe lands on its own edge
  always_comb
  begin
    nxt_port2_output_latch    = port2_output_latch_ff;
    nxt_port3_output_latch    = port3_output_latch_ff;
    nxt_port3_direction       = port3_direction_ff;
    nxt_converter_control_one = converter_control_one_ff;
    nxt_mode                  = mode_ff;
    if (req.wr)
    begin
      case (req.addr)
        DPIO_P2_LATCH_OFF: nxt_port2_output_latch = req.wdata[2:0];
        DPIO_P3_LATCH_OFF:
        begin
          // Bit ops carry pin levels of input bits back into the latch
          if (req.bitop)
            nxt_port3_output_latch = (req.wdata & port3_direction_ff)
                                   | (p3_read & ~port3_direction_ff);
          else
            nxt_port3_output_latch = req.wdata;
        end
        DPIO_P3_DIR_OFF:   nxt_port3_direction       = req.wdata;
        DPIO_ADC_CTRL_OFF: nxt_converter_control_one = req.wdata;
        DPIO_MODE_OFF:     nxt_mode                  = req.wdata;
        // Unmapped writes change nothing
        default:           nxt_mode                  = mode_ff;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        DPIO_P2_LATCH_OFF: nxt_rdata = {DPIO_P2_UPPER_RD, port2_output_latch_ff};
        DPIO_P2_PIN_OFF:   nxt_rdata = {DPIO_P2_UPPER_RD, p2_level};
        // Latch address gives the analog-aware view, pin address the raw pins
        DPIO_P3_LATCH_OFF: nxt_rdata = p3_read;
        DPIO_P3_DIR_OFF:   nxt_rdata = port3_direction_ff;
        DPIO_P3_PIN_OFF:   nxt_rdata = p3_sync;
        DPIO_ADC_CTRL_OFF: nxt_rdata = converter_control_one_ff;
        DPIO_MODE_OFF:     nxt_rdata = mode_ff;
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  // Pin drive, computed from committed latches so outputs move one edge after the write
  always_comb
  begin
    // Three-bit port is open drain: low latch bit pulls the pin
    nxt_p2_out = 3'h0;
    nxt_p2_oe  = ~port2_output_latch_ff;
    if (dual_clock)
    begin
      nxt_p2_oe[DPIO_OSC_IN_PIN]  = 1'b0;
      nxt_p2_oe[DPIO_OSC_OUT_PIN] = 1'b0;
    end
    // Stop mode floats pin zero so the release source is never fought
    if (stop_mode)
      nxt_p2_oe[DPIO_STOP_PIN] = 1'b0;
    // Port three: direction drives, analog selection overrides it
    p3_drv.out = port3_output_latch_ff;
    p3_drv.oe  = port3_direction_ff & ~analog_mask;
    nxt_p3_out = p3_drv.out;
    nxt_p3_oe  = p3_drv.oe;
    nxt_ain    = analog_mask;
    nxt_osc    = dual_clock;
    // Wakeup pins count only while software keeps them as inputs
    nxt_wake   = p3_sync[7:4] & ~port3_direction_ff[7:4];
  end

  // Falling edge on the interrupt pin, driven or not; the previous level resets low
  // like the synchroniser, so release from reset never looks like a fall
  always_comb
  begin
    nxt_int_prev = p2_sync[DPIO_INT_PIN];
    nxt_int_set  = int_prev_ff & ~p2_sync[DPIO_INT_PIN];
  end

  // Software-visible registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      port2_output_latch_ff    <= DPIO_P2_LATCH_RST;
      port3_output_latch_ff    <= DPIO_P3_LATCH_RST;
      port3_direction_ff       <= DPIO_P3_DIR_RST;
      converter_control_one_ff <= DPIO_ADC_CTRL_RST;
      mode_ff                  <= DPIO_MODE_RST;
    end
    else
    begin
      port2_output_latch_ff    <= nxt_port2_output_latch;
      port3_output_latch_ff    <= nxt_port3_output_latch;
      port3_direction_ff       <= nxt_port3_direction;
      converter_control_one_ff <= nxt_converter_control_one;
      mode_ff                  <= nxt_mode;
    end
  end

  // Read data register; idles at zero so a stray sample sees nothing
  always_ff @(posedge mclk)
  begin
    if (srst)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  // Pin drive and status outputs, one edge behind the committed registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      p2_out_ff <= 3'h0;
      p2_oe_ff  <= 3'h0;
      p3_out_ff <= 8'h00;
      p3_oe_ff  <= 8'h00;
      ain_ff    <= 8'h00;
      osc_ff    <= 1'b0;
      wake_ff   <= 4'h0;
    end
    else
    begin
      p2_out_ff <= nxt_p2_out;
      p2_oe_ff  <= nxt_p2_oe;
      p3_out_ff <= nxt_p3_out;
      p3_oe_ff  <= nxt_p3_oe;
      ain_ff    <= nxt_ain;
      osc_ff    <= nxt_osc;
      wake_ff   <= nxt_wake;
    end
  end

  // Interrupt edge detector
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      int_prev_ff <= 1'b0;
      int_set_ff  <= 1'b0;
    end
    else
    begin
      int_prev_ff <= nxt_int_prev;
      int_set_ff  <= nxt_int_set;
    end
  end

  assign reg_rdata            = rdata_ff;
  assign port2_pin_out        = p2_out_ff;
  assign port2_pin_oe         = p2_oe_ff;
  assign port3_pin_out        = p3_out_ff;
  assign port3_pin_oe         = p3_oe_ff;
  assign analog_channel_input = ain_ff;
  assign low_freq_osc_en      = osc_ff;
  assign port2_int_latch_set  = int_set_ff;
  assign key_wakeup_input     = wake_ff;
endmodule

// [dpio_chk.sv]
// Checker: port-level timing and masking relations of the dual port block
`timescale 1ns/10ps
module dpio_chk
  import dpio_pkg::*;
#(
  parameter int P3_W = 8
) (
  input wire logic               mclk,
  input wire logic               srst,
  input wire logic [DPIO_AW-1:0] reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic               reg_bitop,
  input wire logic [7:0]         reg_rdata,
  input wire logic [2:0]         port2_pin_in,
  input wire logic [2:0]         port2_pin_out,
  input wire logic [2:0]         port2_pin_oe,
  input wire logic [P3_W-1:0]    port3_pin_in,
  input wire logic [P3_W-1:0]    port3_pin_out,
  input wire logic [P3_W-1:0]    port3_pin_oe,
  input wire logic [P3_W-1:0]    analog_channel_input,
  input wire logic               low_freq_osc_en,
  input wire logic               port2_int_latch_set,
  input wire logic [3:0]         key_wakeup_input
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // Read data only in the cycle after a read strobe
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  p2_upper_a: assert property ($past(reg_rd) && ($past(reg_addr) == DPIO_P2_LATCH_OFF
    || $past(reg_addr) == DPIO_P2_PIN_OFF) |-> reg_rdata[7:3] == DPIO_P2_UPPER_RD)
    else $error("port two upper read bits wrong");
  rst_state_a: assert property ($fell(srst) |-> port3_pin_oe == '0
    && port2_pin_oe == 3'h0 && analog_channel_input == '0 && !low_freq_osc_en)
    else $error("outputs not at reset state");
  // Resonator pins released while dual clock is on
  osc_pins_a: assert property (low_freq_osc_en [*2] |-> port2_pin_oe[2:1] == 2'h0)
    else $error("resonator pins driven");
  int_edge_a: assert property ($fell(port2_pin_in[0]) |-> ##[1:4] port2_int_latch_set)
    else $error("falling edge gave no interrupt pulse");
  int_pulse_a: assert property (port2_int_latch_set |=> !port2_int_latch_set)
    else $error("interrupt pulse too long");
  ain_one_a: assert property ($onehot0(analog_channel_input)
    && analog_channel_input[1:0] == 2'h0) else $error("analog select not one pin");
  // Guarded by stability so a one-edge skew between outputs is tolerated
  ain_drive_a: assert property ($stable(analog_channel_input)
    |-> (port3_pin_oe & analog_channel_input) == '0) else $error("analog pin driven");
  wake_dir_a: assert property ($stable(port3_pin_oe)
    |-> (key_wakeup_input & port3_pin_oe[7:4]) == 4'h0) else $error("wakeup on output pin");
  out_follow_a: assert property (reg_wr && !reg_bitop && reg_addr == DPIO_P3_LATCH_OFF
    |-> ##2 port3_pin_out == $past(reg_wdata, 2)) else $error("pin output late or wrong");
endmodule

bind dpio_top dpio_chk #(.P3_W(P3_W)) u_chk (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bitop(reg_bitop),
  .reg_rdata(reg_rdata), .port2_pin_in(port2_pin_in), .port2_pin_out(port2_pin_out),
  .port2_pin_oe(port2_pin_oe), .port3_pin_in(port3_pin_in), .port3_pin_out(port3_pin_out),
  .port3_pin_oe(port3_pin_oe), .analog_channel_input(analog_channel_input),
  .low_freq_osc_en(low_freq_osc_en), .port2_int_latch_set(port2_int_latch_set),
  .key_wakeup_input(key_wakeup_input));

// [dpio_pins.sv]
// Pin model: resolves port drivers against outside sources
`timescale 1ns/10ps
module dpio_pins (
  input  wire logic [2:0] p2_out,
  input  wire logic [2:0] p2_oe,
  input  wire logic [2:0] p2_ext,
  input  wire logic [7:0] p3_out,
  input  wire logic [7:0] p3_oe,
  input  wire logic [7:0] p3_ext,
  output logic      [2:0] p2_lvl,
  output logic      [7:0] p3_lvl
);
  // Driven bits follow the port; released bits show the outside level
  assign p2_lvl = (p2_oe & p2_out) | (~p2_oe & p2_ext);
  assign p3_lvl = (p3_oe & p3_out) | (~p3_oe & p3_ext);
endmodule

// [dual_port_io_with_analog_share_bench.sv]
// Bench: register round trips, reset, pin drive, analog, bit operation, port two
`timescale 1ns/10ps
module dual_port_io_with_analog_share_bench;
  import dpio_pkg::*;
  logic        mclk, srst, reg_wr, reg_rd, reg_bitop, osc_en, int_set, hit;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, p3_ext, p3_in, p3_out, p3_oe, ain;
  logic [2:0]  p2_ext, p2_in, p2_out, p2_oe;
  logic [3:0]  wake;
  logic [23:0] rows [5];
  int          n_fail, n_tests, i;

  // Free-running 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  dpio_top DUT (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bitop(reg_bitop), .reg_rdata(reg_rdata),
    .port2_pin_in(p2_in), .port2_pin_out(p2_out), .port2_pin_oe(p2_oe),
    .port3_pin_in(p3_in), .port3_pin_out(p3_out), .port3_pin_oe(p3_oe),
    .analog_channel_input(ain), .low_freq_osc_en(osc_en),
    .port2_int_latch_set(int_set), .key_wakeup_input(wake));
  dpio_pins u_pins (.p2_out(p2_out), .p2_oe(p2_oe), .p2_ext(p2_ext), .p3_out(p3_out),
    .p3_oe(p3_oe), .p3_ext(p3_ext), .p2_lvl(p2_in), .p3_lvl(p3_in));

  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus cycles: strobes last one cycle, read data sampled the cycle after
  task wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(posedge mclk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; reg_bitop <= b;
    @(posedge mclk);
    reg_wr <= 1'b0; reg_bitop <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Latch, output flop and two sync flops all settle within four edges
  task settle;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task do_rst;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_bitop = 1'b0; reg_addr = 8'h00;
    reg_wdata = 8'h00; p3_ext = 8'h3c; p2_ext = 3'h7; n_fail = 0; n_tests = 0;
    rows[0] = {DPIO_P3_DIR_OFF, 8'h5a, 8'h5a};
    rows[1] = {DPIO_MODE_OFF, 8'h03, 8'h03};
    rows[2] = {DPIO_ADC_CTRL_OFF, 8'h15, 8'h15};
    rows[3] = {DPIO_P2_LATCH_OFF, 8'hff, 8'h07};
    rows[4] = {8'h40, 8'hff, 8'h00};
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    // Ordinary round trips, the unmapped address among them
    for (i = 0; i < 5; i++)
    begin
      wr(rows[i][23:16], rows[i][15:8], 1'b0);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    $display("end rows");
    // Reset in mid-run restores the power-up state
    do_rst;
    rd(DPIO_P2_LATCH_OFF, 8'h07);
    rd(DPIO_P3_DIR_OFF, 8'h00);
    rd(DPIO_ADC_CTRL_OFF, 8'h10);
    rd(DPIO_P3_LATCH_OFF, 8'h3c);
    chk({4'h0, wake}, 8'h03);
    $display("end reset");
    // Low nibble driven, high nibble from outside
    wr(DPIO_P3_DIR_OFF, 8'h0f, 1'b0);
    wr(DPIO_P3_LATCH_OFF, 8'ha5, 1'b0);
    settle;
    chk(p3_out, 8'ha5);
    chk(p3_oe, 8'h0f);
    rd(DPIO_P3_LATCH_OFF, 8'h35);
    // Channel one takes pin three away from its output driver
    wr(DPIO_ADC_CTRL_OFF, 8'h01, 1'b0);
    settle;
    chk(ain, 8'h08);
    chk(p3_oe, 8'h07);
    rd(DPIO_P3_LATCH_OFF, 8'h35);
    rd(DPIO_P3_PIN_OFF, 8'h3d);
    for (i = 0; i < 8; i++)
    begin
      wr(DPIO_ADC_CTRL_OFF, i[7:0], 1'b0);
      settle;
      chk(ain, (i < 6) ? (8'h04 << i) : 8'h00);
    end
    $display("end analog");
    // Bit operation copies input pin levels into their latches
    wr(DPIO_ADC_CTRL_OFF, 8'h10, 1'b0);
    wr(DPIO_P3_LATCH_OFF, 8'h00, 1'b1);
    wr(DPIO_P3_DIR_OFF, 8'hff, 1'b0);
    settle;
    chk(p3_out, 8'h30);
    $display("end bitop");
    // Own drive on pin zero must still raise the interrupt pulse
    wr(DPIO_P2_LATCH_OFF, 8'h06, 1'b0);
    hit = 1'b0;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      #1 if (int_set === 1'b1) hit = 1'b1;
    end
    chk({7'h0, hit}, 8'h01);
    chk({5'h0, p2_oe}, 8'h01);
    chk({5'h0, p2_out}, 8'h00);
    rd(DPIO_P2_PIN_OFF, 8'h06);
    wr(DPIO_MODE_OFF, 8'h02, 1'b0);
    settle;
    chk({5'h0, p2_oe}, 8'h00);
    wr(DPIO_P2_LATCH_OFF, 8'h00, 1'b0);
    wr(DPIO_MODE_OFF, 8'h01, 1'b0);
    settle;
    chk({5'h0, p2_oe}, 8'h01);
    chk({7'h0, osc_en}, 8'h01);
    rd(DPIO_P2_LATCH_OFF, 8'h00);
    rd(DPIO_P2_PIN_OFF, 8'h06);
    $display("end port2");
    give_verdict;
  end
endmodule
